// [bench/aorc_bank_properties.sv]
// Concurrent checks on the property port and configuration outputs of the bank.
// Assumes binding to aorc_bank; one clock, synchronous active-high reset.
`include "aorc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module aorc_bank_properties #(
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        prop_wr,
    input wire logic        prop_rd,
    input wire logic [15:0] prop_addr,
    input wire logic [15:0] prop_wdata,
    input wire logic [15:0] prop_rdata,
    input wire logic        prop_err,
    input wire logic        clear_to_send,
    input wire logic        ext_ref_clock,
    input wire logic        internal_ref_clock,
    input wire logic        auto_freq_correction,
    input wire logic        rolloff_enable,
    input wire logic [23:0] sample_data,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic        audio_bit_clock,
    input wire logic        audio_frame_sync,
    input wire logic        audio_data_out,
    input wire logic        audio_out_enable
);
    // Accepted requests only; anything raised while busy is dropped by the bank
    wire logic acc = (prop_wr | prop_rd) & clear_to_send;
    wire logic wr_ok = prop_wr & clear_to_send;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    chk_cts_window: assert property (
        acc |=> !clear_to_send [*2] ##1 clear_to_send) else $error("busy window wrong");
    chk_cts_cause: assert property (
        $fell(clear_to_send) |-> $past(acc)) else $error("busy without request");
    chk_rate_on: assert property (
        wr_ok && prop_addr == `AORC_OFS_RATE |=> audio_out_enable == ($past(prop_wdata) != 16'h0000))
        else $error("enable does not follow rate");
    chk_quiet_off: assert property (
        !audio_out_enable [*2] |-> !audio_data_out) else $error("data while disabled");
    chk_rolloff_bit: assert property (
        wr_ok && prop_addr == `AORC_OFS_ROLLOFF |=> rolloff_enable == $past(prop_wdata[0]))
        else $error("rolloff not bit 0");
    chk_rolloff_hold: assert property (
        !wr_ok |=> $stable(rolloff_enable)) else $error("rolloff moved without write");
    chk_afc_flag: assert property (
        wr_ok && prop_addr == `AORC_OFS_REFFREQ |=> auto_freq_correction == ($past(prop_wdata) != 16'h0000))
        else $error("correction flag wrong");
    chk_div_reject: assert property (
        wr_ok && prop_addr == `AORC_OFS_REFDIV && prop_wdata[11:0] == 12'h000 |=> prop_err)
        else $error("zero divider accepted");

    // Main scenarios reached
    cover property (acc && prop_addr == `AORC_OFS_RATE);
    cover property (prop_wr && !clear_to_send);
    cover property ($rose(audio_out_enable));
    cover property (!sample_ready);
endmodule // aorc_bank_properties
`default_nettype wire

// [bench/aorc_partner.sv]
// Far side: bit clock, frame sync and reference clock source plus a serial receiver.
// Assumes everything runs on mclk; the bench sets the receiver's framing inputs.
`timescale 1ns/10ps
`default_nettype none
module aorc_partner (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        audio_data_out,
    input  wire logic        rx_fall,
    input  wire logic        rx_dsp,
    input  wire logic        rx_lead,
    input  wire logic [6:0]  rx_bits,
    output var  logic        audio_bit_clock,
    output var  logic        audio_frame_sync,
    output var  logic        ext_ref_clock,
    output var  logic [23:0] rx_word,
    output var  logic [15:0] rx_cnt
);
    logic [1:0] div;
    logic [4:0] slot;
    logic [6:0] idx;
    logic [2:0] rdiv;
    wire  [6:0] skip = {6'h00, rx_lead} + {6'h00, rx_fall};

    // Clocks run from reset on, before any enable, so the bank never stalls
    // Samples on the edge opposite to launch; word count starts at each frame mark
    always @(posedge mclk)
    begin
        if (srst)
        begin
            div <= 2'h0;
            slot <= 5'h00;
            idx <= 7'h7f;
            rx_cnt <= 16'h0000;
            audio_bit_clock <= 1'b0;
            audio_frame_sync <= 1'b0;
        end
        else
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
            begin
                audio_bit_clock <= !audio_bit_clock;
                if (audio_bit_clock)
                    slot <= slot + 5'h01;
                if (audio_bit_clock && slot == 5'h1f)
                    audio_frame_sync <= !audio_frame_sync;
                if (audio_bit_clock && slot == 5'h1f && (!rx_dsp || !audio_frame_sync))
                    idx <= 7'h00;
                else if (audio_bit_clock == !rx_fall && idx != 7'h7f)
                begin
                    if (idx >= skip && idx < skip + rx_bits)
                        rx_word <= {rx_word[22:0], audio_data_out};
                    if (idx == skip + rx_bits - 7'h01)
                        rx_cnt <= rx_cnt + 16'h0001;
                    idx <= idx + 7'h01;
                end
            end
        end
    end

    // Reference clock never stops, as correction and tuning need it
    always @(posedge mclk)
    begin
        rdiv <= (srst || rdiv == 3'h4) ? 3'h0 : rdiv + 3'h1;
        ext_ref_clock <= srst ? 1'b0 : ext_ref_clock ^ (rdiv == 3'h4);
    end
endmodule // aorc_partner
`default_nettype wire

// [bench/audio_out_internal_ref_clock_config_tb.sv]
// Self-checking bench for the property bank, its reference divider and audio output.
// Assumes aorc_bank, aorc_partner and the bound checker; inputs change on falling mclk.
`include "aorc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module audio_out_internal_ref_clock_config_tb;
    logic mclk, srst, prop_wr, prop_rd, prop_err, clear_to_send, ext_ref_clock;
    logic internal_ref_clock, auto_freq_correction, rolloff_enable, sample_valid;
    logic sample_ready, audio_bit_clock, audio_frame_sync, audio_data_out, audio_out_enable;
    logic rx_fall, rx_dsp, rx_lead;
    logic [6:0]  rx_bits;
    logic [15:0] prop_addr, prop_wdata, prop_rdata, rx_cnt, c;
    logic [23:0] sample_data, rx_word, msk;
    logic [3:0]  md;
    integer err_total = 0;
    integer samples_checked = 0;
    integer i, n;

    aorc_bank #(.DEPTH(32), .AW(5)) u_aorc_bank (.*);
    aorc_partner u_aorc_partner (.*);

    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end

    task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    // One access; waits for clear-to-send so a busy window is never hit by accident
    task acc(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    begin
        n = 0;
        while (clear_to_send !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        chk("cts_ready", clear_to_send, 24'h1);
        prop_wr = wr;
        prop_rd = !wr;
        prop_addr = addr;
        prop_wdata = data;
        @(negedge mclk);
        prop_wr = 1'b0;
        prop_rd = 1'b0;
        chk("busy", clear_to_send, 24'h0);
    end
    endtask

    task rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
    begin
        acc(1'b0, addr, 16'h0000);
        chk(what, prop_rdata, exp);
    end
    endtask

    // Push until the FIFO refuses; n ends as the number of samples taken
    task fill;
    begin
        sample_valid = 1'b1;
        n = 0;
        while (sample_ready === 1'b1 && n < 40)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        sample_valid = 1'b0;
    end
    endtask

    // Internal reference period in mclk cycles, after one settling period
    task meas(input integer exp);
        time t;
    begin
        repeat (2) @(posedge internal_ref_clock);
        t = $time;
        @(posedge internal_ref_clock);
        chk("ref_period", ($time - t) / 10, exp);
        @(negedge mclk);
    end
    endtask

    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // Hang guard, nearly three times the expected run
    initial
    begin
        #600000;
        err_total = err_total + 1;
        give_verdict;
    end

    // Main sequence
    initial
    begin
        srst = 1'b1;
        {prop_wr, prop_rd, sample_valid, rx_fall, rx_dsp, rx_lead} = 6'h00;
        prop_addr = 16'h0000;
        prop_wdata = 16'h0000;
        sample_data = 24'h9a5c3e;
        rx_bits = 7'd16;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        rd(`AORC_OFS_FORMAT, `AORC_RST_FORMAT, "format");
        rd(`AORC_OFS_RATE, `AORC_RST_RATE, "rate");
        rd(`AORC_OFS_REFFREQ, `AORC_RST_REFFREQ, "freq");
        rd(`AORC_OFS_REFDIV, `AORC_RST_REFDIV, "div");
        rd(`AORC_OFS_ROLLOFF, `AORC_RST_ROLLOFF, "rolloff");
        meas(10);
        $display("test reset_values done");
        acc(1'b1, `AORC_OFS_REFFREQ, 16'h0000);
        chk("afc_off", auto_freq_correction, 24'h0);
        acc(1'b1, `AORC_OFS_REFFREQ, 16'd31130);
        rd(`AORC_OFS_REFFREQ, 16'd31130, "freq_low");
        chk("afc_on", auto_freq_correction, 24'h1);
        acc(1'b1, `AORC_OFS_ROLLOFF, 16'h0001);
        // A second write inside the busy window must be dropped
        @(negedge mclk);
        prop_wr = 1'b1;
        prop_wdata = 16'h0000;
        @(negedge mclk);
        rd(`AORC_OFS_ROLLOFF, 16'h0001, "refused");
        chk("rolloff_on", rolloff_enable, 24'h1);
        $display("test write_back done");
        acc(1'b1, `AORC_OFS_REFDIV, 16'h0000);
        chk("div_zero_err", prop_err, 24'h1);
        rd(16'h0103, 16'h0000, "unmapped");
        chk("unmapped_err", prop_err, 24'h1);
        acc(1'b1, `AORC_OFS_REFDIV, 16'h0003);
        chk("div_ok", prop_err, 24'h0);
        meas(30);
        $display("test divider done");
        // Capacity is the 32-word store plus the registered read port
        fill;
        chk("fifo_fill", n, 24'd33);
        // Every framing code, both edges and every width, one table row each
        for (i = 0; i < 4; i = i + 1)
        begin
            md = (i == 0) ? `AORC_MODE_I2S : (i == 1) ? `AORC_MODE_LJ :
                 (i == 2) ? `AORC_MODE_DSP2 : `AORC_MODE_DSP1;
            rx_bits = (i == 0) ? 7'd16 : (i == 1) ? 7'd20 : (i == 2) ? 7'd24 : 7'd8;
            rx_fall = i[0];
            rx_dsp = md[3];
            rx_lead = (i == 0 || i == 2);
            msk = 24'hffffff >> (7'd24 - rx_bits);
            acc(1'b1, `AORC_OFS_FORMAT, {8'h00, i[0], md, 1'b0, i[1:0]});
            acc(1'b1, `AORC_OFS_RATE, 16'hbb80);
            chk("enable", audio_out_enable, 24'h1);
            c = rx_cnt;
            for (n = 0; n < 2000 && rx_cnt != c + 16'd3; n = n + 1)
                @(negedge mclk);
            chk("frames", rx_cnt, c + 16'd3);
            chk("word", rx_word & msk, sample_data & msk);
            acc(1'b1, `AORC_OFS_RATE, 16'h0000);
            chk("disable", audio_out_enable, 24'h0);
        end
        $display("test audio_formats done");
        acc(1'b1, `AORC_OFS_RATE, 16'h7d00);
        c = rx_cnt;
        for (n = 0; n < 40000 && rx_cnt != c + 16'd34; n = n + 1)
            @(negedge mclk);
        chk("drain_frames", rx_cnt, c + 16'd34);
        chk("fifo_drain", sample_ready, 24'h1);
        // Stop consumption, then an emptied FIFO must take a full load again
        acc(1'b1, `AORC_OFS_RATE, 16'h0000);
        fill;
        chk("fifo_refill", n, 24'd33);
        $display("test fifo_drain done");
        give_verdict;
    end
endmodule // audio_out_internal_ref_clock_config_tb
bind aorc_bank aorc_bank_properties #(.DEPTH(DEPTH), .AW(AW)) u_aorc_bank_properties (.*);
`default_nettype wire

// [common/aorc_defines.vh]
// Constants for the audio output and reference clock property bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef AORC_DEFINES_VH
`define AORC_DEFINES_VH
`define AORC_OFS_FORMAT      16'h0102
`define AORC_OFS_RATE        16'h0104
`define AORC_OFS_REFFREQ     16'h0201
`define AORC_OFS_REFDIV      16'h0202
`define AORC_OFS_ROLLOFF     16'h3100
`define AORC_RST_FORMAT      16'h0000
`define AORC_RST_RATE        16'h0000
`define AORC_RST_REFFREQ     16'h8000
`define AORC_RST_REFDIV      16'h0001
`define AORC_RST_ROLLOFF     16'h0000
`define AORC_FMT_EDGE_BIT    7
`define AORC_FMT_MODE_HI     6
`define AORC_FMT_MODE_LO     3
`define AORC_FMT_SIZE_HI     1
`define AORC_FMT_SIZE_LO     0
`define AORC_MODE_I2S        4'h0
`define AORC_MODE_LJ         4'h6
`define AORC_MODE_DSP2       4'h8
`define AORC_MODE_DSP1       4'hc
`define AORC_SIZE_16         2'h0
`define AORC_SIZE_20         2'h1
`define AORC_SIZE_24         2'h2
`define AORC_SIZE_8          2'h3
`define AORC_DIV_HI          11
`define AORC_ROLLOFF_BIT     0
`define AORC_CTS_DELAY       4'h2
`endif

// [hdl/aorc_bank.v]
// Property bank for the digital audio output, reference prescaler and AM roll-off.
// Assumes a property port from the command engine, and audio_bit_clock and
// audio_frame_sync sampled as synchronous inputs on mclk.
`include "aorc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module aorc_bank #(
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        prop_wr,
    input  wire        prop_rd,
    input  wire [15:0] prop_addr,
    input  wire [15:0] prop_wdata,
    output reg  [15:0] prop_rdata,
    output reg         prop_err,
    output reg         clear_to_send,
    input  wire        ext_ref_clock,
    output reg         internal_ref_clock,
    output wire        auto_freq_correction,
    output wire        rolloff_enable,
    input  wire [23:0] sample_data,
    input  wire        sample_valid,
    output wire        sample_ready,
    input  wire        audio_bit_clock,
    input  wire        audio_frame_sync,
    output reg         audio_data_out,
    output wire        audio_out_enable
);
    reg  [15:0] audio_out_format_cfg_r;
    reg  [15:0] audio_out_rate_cfg_r;
    reg  [15:0] reference_frequency_cfg_r;
    reg  [15:0] reference_divider_cfg_r;
    reg  [15:0] am_audio_rolloff_select_r;
    reg  [3:0]  cts_cnt_r;
    reg  [11:0] div_cnt_r;
    reg         rck_d_r;
    reg         bck_d_r;
    reg         fs_d_r;
    reg  [4:0]  bit_idx_r;
    reg  [23:0] shift_r;
    reg         word_act_r;
    reg  [1:0]  lead_r;
    wire [23:0] fifo_data;
    wire        fifo_valid;
    wire        fifo_take;
    wire        launch_edge_select;
    wire [3:0]  framing_mode_code;
    wire [1:0]  sample_width_code;
    wire [11:0] reference_divider_value;
    wire        rck_rise;
    wire        bck_launch;
    wire        fs_rise;
    wire        fs_edge;
    wire        frame_mark;
    reg  [4:0]  word_bits;
    reg  [1:0]  lead_bits;

    assign launch_edge_select      = audio_out_format_cfg_r[`AORC_FMT_EDGE_BIT];
    assign framing_mode_code       = audio_out_format_cfg_r[`AORC_FMT_MODE_HI:`AORC_FMT_MODE_LO];
    assign sample_width_code       = audio_out_format_cfg_r[`AORC_FMT_SIZE_HI:`AORC_FMT_SIZE_LO];
    assign reference_divider_value = reference_divider_cfg_r[`AORC_DIV_HI:0];
    assign audio_out_enable        = (audio_out_rate_cfg_r != 16'h0000);
    assign auto_freq_correction    = (reference_frequency_cfg_r != 16'h0000);
    assign rolloff_enable          = am_audio_rolloff_select_r[`AORC_ROLLOFF_BIT];

    // Property writes and the clear-to-send busy window
    always @(posedge mclk)
    begin
        if (srst)
        begin
            audio_out_format_cfg_r    <= `AORC_RST_FORMAT;
            audio_out_rate_cfg_r      <= `AORC_RST_RATE;
            reference_frequency_cfg_r <= `AORC_RST_REFFREQ;
            reference_divider_cfg_r   <= `AORC_RST_REFDIV;
            am_audio_rolloff_select_r <= `AORC_RST_ROLLOFF;
            cts_cnt_r                 <= 4'h0;
            clear_to_send             <= 1'b1;
            prop_err                  <= 1'b0;
            prop_rdata                <= 16'h0000;
        end
        else
        begin
            if ((prop_wr | prop_rd) & clear_to_send)
            begin
                // Busy for a short window, then ready again
                clear_to_send <= 1'b0;
                cts_cnt_r     <= `AORC_CTS_DELAY;
                prop_err      <= 1'b0;
                prop_rdata    <= 16'h0000;
                case (prop_addr)
                    `AORC_OFS_FORMAT:  prop_rdata <= audio_out_format_cfg_r;
                    `AORC_OFS_RATE:    prop_rdata <= audio_out_rate_cfg_r;
                    `AORC_OFS_REFFREQ: prop_rdata <= reference_frequency_cfg_r;
                    `AORC_OFS_REFDIV:  prop_rdata <= reference_divider_cfg_r;
                    `AORC_OFS_ROLLOFF: prop_rdata <= am_audio_rolloff_select_r;
                    default:           prop_err   <= 1'b1;
                endcase
                if (prop_wr)
                begin
                    case (prop_addr)
                        `AORC_OFS_FORMAT:  audio_out_format_cfg_r    <= prop_wdata;
                        `AORC_OFS_RATE:    audio_out_rate_cfg_r      <= prop_wdata;
                        `AORC_OFS_REFFREQ: reference_frequency_cfg_r <= prop_wdata;
                        // Zero divider is illegal; keep the old one
                        `AORC_OFS_REFDIV:
                        begin
                            if (prop_wdata[`AORC_DIV_HI:0] != 12'h000)
                                reference_divider_cfg_r <= prop_wdata;
                            else
                                prop_err <= 1'b1;
                        end
                        `AORC_OFS_ROLLOFF: am_audio_rolloff_select_r <= prop_wdata;
                        default:           prop_err <= 1'b1;
                    endcase
                end
            end
            else if (!clear_to_send)
            begin
                if (cts_cnt_r == 4'h1)
                    clear_to_send <= 1'b1;
                cts_cnt_r <= cts_cnt_r - 4'h1;
            end
        end
    end

    // Reference prescaler: divide external clock edges by the divider value
    assign rck_rise = ext_ref_clock & ~rck_d_r;
    always @(posedge mclk)
    begin
        if (srst)
        begin
            rck_d_r            <= 1'b0;
            div_cnt_r          <= 12'h000;
            internal_ref_clock <= 1'b0;
        end
        else
        begin
            rck_d_r <= ext_ref_clock;
            if (rck_rise)
            begin
                // Output set high at each terminal count, low again from the half count
                if (div_cnt_r >= reference_divider_value - 12'h001)
                begin
                    div_cnt_r          <= 12'h000;
                    internal_ref_clock <= 1'b1;
                end
                else
                begin
                    div_cnt_r <= div_cnt_r + 12'h001;
                    if (div_cnt_r + 12'h001 >= {1'b0, reference_divider_value[11:1]})
                        internal_ref_clock <= 1'b0;
                end
            end
            else if (rck_d_r & ~ext_ref_clock & (reference_divider_value == 12'h001))
            begin
                // A divider of one has no half count, so follow the external fall
                internal_ref_clock <= 1'b0;
            end
        end
    end

    // Word width and the number of bit clocks between sync and MSB
    always @*
    begin
        case (sample_width_code)
            `AORC_SIZE_16: word_bits = 5'd16;
            `AORC_SIZE_20: word_bits = 5'd20;
            `AORC_SIZE_24: word_bits = 5'd24;
            default:       word_bits = 5'd8;
        endcase
        case (framing_mode_code)
            `AORC_MODE_I2S:  lead_bits = 2'd1;
            `AORC_MODE_LJ:   lead_bits = 2'd0;
            `AORC_MODE_DSP2: lead_bits = 2'd1;
            `AORC_MODE_DSP1: lead_bits = 2'd0;
            default:         lead_bits = 2'd1;
        endcase
    end

    // Launch on the selected edge of the sampled bit clock
    assign bck_launch = launch_edge_select ? (bck_d_r & ~audio_bit_clock)
                                           : (~bck_d_r & audio_bit_clock);
    assign fs_rise    = audio_frame_sync & ~fs_d_r;
    assign fs_edge    = audio_frame_sync ^ fs_d_r;
    // Left-justified and I2S start a word on each sync edge, the pulse modes on the rise
    assign frame_mark = (framing_mode_code == `AORC_MODE_I2S ||
                         framing_mode_code == `AORC_MODE_LJ) ? fs_edge : fs_rise;
    assign fifo_take  = frame_mark & audio_out_enable;

    // Serialiser: each frame mark while enabled loads the next sample if the FIFO holds one, so I2S and left-justified send a new one in each slot
    always @(posedge mclk)
    begin
        if (srst)
        begin
            bck_d_r        <= 1'b0;
            fs_d_r         <= 1'b0;
            bit_idx_r      <= 5'd0;
            shift_r        <= 24'h000000;
            word_act_r     <= 1'b0;
            lead_r         <= 2'd0;
            audio_data_out <= 1'b0;
        end
        else
        begin
            bck_d_r <= audio_bit_clock;
            fs_d_r  <= audio_frame_sync;
            if (!audio_out_enable)
            begin
                // Output held quiet while rate is zero
                word_act_r     <= 1'b0;
                audio_data_out <= 1'b0;
            end
            else if (frame_mark)
            begin
                if (fifo_valid)
                    shift_r <= fifo_data << (5'd24 - word_bits);
                lead_r     <= lead_bits;
                bit_idx_r  <= word_bits;
                word_act_r <= 1'b1;
            end
            else if (bck_launch & word_act_r)
            begin
                if (lead_r != 2'd0)
                    lead_r <= lead_r - 2'd1;
                else if (bit_idx_r != 5'd0)
                begin
                    audio_data_out <= shift_r[23];
                    shift_r        <= {shift_r[22:0], 1'b0};
                    bit_idx_r      <= bit_idx_r - 5'd1;
                end
                else
                begin
                    audio_data_out <= 1'b0;
                    word_act_r     <= 1'b0;
                end
            end
        end
    end

    // Samples wait in the FIFO; a stalled producer sees sample_ready low
    aorc_fifo #(
        .WIDTH (24),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );
endmodule // aorc_bank
`default_nettype wire

// [hdl/aorc_fifo.v]
// Sample FIFO with a registered read port.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module aorc_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             mclk,
    input  wire             srst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_r;
    reg [AW:0]      rp_r;
    wire            empty;
    wire            full;
    wire            pop;
    wire            push;

    // Extra pointer bit tells full from empty
    assign empty    = (wp_r == rp_r);
    assign full     = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign in_ready = ~full;
    assign push     = in_valid & ~full;
    assign pop      = ~empty & (~out_valid | out_ready);

    // Storage has no reset; only pointers matter
    always @(posedge mclk)
    begin
        if (push)
            mem[wp_r[AW-1:0]] <= in_data;
    end

    // Pointers and output register
    always @(posedge mclk)
    begin
        if (srst)
        begin
            wp_r      <= {(AW+1){1'b0}};
            rp_r      <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
            begin
                rp_r      <= rp_r + 1'b1;
                out_data  <= mem[rp_r[AW-1:0]];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end
endmodule // aorc_fifo
`default_nettype wire
